// >>> design/cmil_press_timer.sv
package cmil_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned PRESS_MIN_MS  = 100;
  localparam int unsigned PRESS_MAX_MS  = 4000;
  localparam int unsigned PRESS_MIN_CYC = CYC_PER_MS * PRESS_MIN_MS;
  localparam int unsigned PRESS_MAX_CYC = CYC_PER_MS * PRESS_MAX_MS;
  localparam int unsigned PRESS_CNT_W   = 29;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_COUNT     = 8'h08;
  localparam int unsigned CTRL_BEAM_EN  = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_LOCK_BIT   = 3;
  localparam int unsigned ST_OUT_BIT    = 4;
  localparam int unsigned ST_RXCH_BIT   = 5;
  localparam int unsigned ST_TXCH_BIT   = 6;
  localparam int unsigned ST_FAULT_BIT  = 7;
  localparam int unsigned ST_RANGE_BIT  = 8;
  localparam int unsigned ST_STATE_LSB  = 9;
  localparam int unsigned CNT_ACC_LSB   = 16;
  localparam logic [7:0]  CARRIER_HALF_FIRST  = 8'h19;
  localparam logic [7:0]  CARRIER_HALF_SECOND = 8'h1e;
  localparam logic [1:0]  INIT_WAIT     = 2'h3;
  localparam logic [2:0]  MODE_ONE      = 3'h1;
  localparam logic [2:0]  MODE_TWO      = 3'h2;
  localparam logic [2:0]  MODE_THREE    = 3'h3;
  localparam logic [2:0]  MODE_FOUR     = 3'h4;
  localparam logic [2:0]  MODE_SIX      = 3'h6;

  typedef enum logic [2:0] {
    ST_INIT   = 3'b000,
    ST_AUTO   = 3'b001,
    ST_LOCKED = 3'b010,
    ST_ON     = 3'b011,
    ST_FAULT  = 3'b100
  } cmil_state_type;

  function automatic logic cmil_mode_legal(input logic [2:0] m);
    return (m == MODE_ONE) || (m == MODE_TWO) || (m == MODE_THREE) ||
           (m == MODE_FOUR) || (m == MODE_SIX);
  endfunction : cmil_mode_legal

  function automatic logic cmil_mode_interlock(input logic [2:0] m);
    return (m == MODE_FOUR) || (m == MODE_SIX);
  endfunction : cmil_mode_interlock
endpackage : cmil_pkg

`timescale 1ns/10ps
module cmil_press_timer
  import cmil_pkg::*;
#(
  parameter int unsigned MIN_CYC = PRESS_MIN_CYC,
  parameter int unsigned MAX_CYC = PRESS_MAX_CYC,
  parameter int unsigned CNT_W   = PRESS_CNT_W
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pressed,
  output logic      accept,
  output logic      reject
);
  localparam logic [CNT_W-1:0] MIN_L = CNT_W'(MIN_CYC);
  localparam logic [CNT_W-1:0] MAX_L = CNT_W'(MAX_CYC);
  localparam logic [CNT_W-1:0] SAT_L = CNT_W'(MAX_CYC + 1);

  logic [CNT_W-1:0] hold_reg;
  logic             prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_reg <= '0;
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pressed;
      if (pressed) begin
        // saturate just past the limit so an overlong press stays invalid
        if (hold_reg != SAT_L) begin
          hold_reg <= hold_reg + 1'b1;
        end
      end else begin
        hold_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accept <= 1'b0;
      reject <= 1'b0;
    end else begin
      accept <= prev_reg && !pressed && hold_reg >= MIN_L && hold_reg <= MAX_L;
      reject <= prev_reg && !pressed && (hold_reg < MIN_L || hold_reg > MAX_L);
    end
  end
endmodule : cmil_press_timer

// >>> design/cmil_top.sv
// Behaviour
// - operating mode comes from wiring; each mode fixes its function set.
// - modes 1, 2 and 3 keep the restart interlock disabled.
// - modes 4 and 6 enable the restart interlock automatically.
// - with interlock, outputs stay off after a field violation until reset.
// - with interlock, outputs stay off after supply return until reset.
// - reset is accepted only as press-release held 0.1 s to 4 s.
// - a valid reset while locked, with field clear and supply present, switches the outputs on.
// - no contactor feedback check exists in any mode.
// - factory state uses the first receive channel.
// - strapped power-up switches the receiver to the second channel, stored.
// - each further strapped power-up toggles the stored channel again.
// - transmitter channel follows supply polarity.
// - beams are modulated to tell them from ambient light.
// - range pin wiring halves the transmit power.
`timescale 1ns/10ps
module cmil_top
  import cmil_pkg::*;
#(
  parameter int unsigned PRESS_MIN_CYC_P = PRESS_MIN_CYC,
  parameter int unsigned PRESS_MAX_CYC_P = PRESS_MAX_CYC,
  parameter int unsigned PRESS_CNT_W_P   = PRESS_CNT_W
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic [2:0]        MODE_SEL,
  input  wire logic              FIELD_CLEAR,
  input  wire logic              RESET_BTN,
  input  wire logic              STRAP_TIED,
  input  wire logic              NV_CHANNEL,
  input  wire logic              SUPPLY_OK,
  input  wire logic              TX_POLARITY_REV,
  input  wire logic              RANGE_REDUCE,
  output logic                   SAFETY_OUT,
  output logic                   INTERLOCK_WAIT,
  output logic                   RX_CHANNEL,
  output logic                   TX_CHANNEL,
  output logic                   BEAM_MOD,
  output logic                   TX_POWER_HALF,
  output logic                   NV_WR,
  output logic                   NV_DATA
);

  logic [9:0]     pin_meta_reg;
  logic [9:0]     pin_sync_reg;
  logic [2:0]     mode_sync;
  logic           field_sync;
  logic           btn_sync;
  logic           strap_sync;
  logic           nv_sync;
  logic           supply_sync;
  logic           pol_sync;
  logic           range_sync;
  logic           press_accept;
  logic           press_reject;
  logic [1:0]     init_reg;
  logic [2:0]     mode_cap_reg;
  logic           mode_moved;
  cmil_state_type state_reg;
  cmil_state_type state_next;
  logic [31:0]    ctrl_reg;
  logic [15:0]    rej_cnt_reg;
  logic [15:0]    acc_cnt_reg;
  logic [7:0]     carrier_reg;
  logic [7:0]     carrier_half;
  logic           count_clr;

  // all pins are asynchronous to CLK_SYS
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_meta_reg <= 10'h000;
      pin_sync_reg <= 10'h000;
    end else begin
      pin_meta_reg <= {MODE_SEL, FIELD_CLEAR, RESET_BTN, STRAP_TIED, NV_CHANNEL,
                       SUPPLY_OK, TX_POLARITY_REV, RANGE_REDUCE};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign mode_sync   = pin_sync_reg[9:7];
  assign field_sync  = pin_sync_reg[6];
  assign btn_sync    = pin_sync_reg[5];
  assign strap_sync  = pin_sync_reg[4];
  assign nv_sync     = pin_sync_reg[3];
  assign supply_sync = pin_sync_reg[2];
  assign pol_sync    = pin_sync_reg[1];
  assign range_sync  = pin_sync_reg[0];

  cmil_press_timer #(
    .MIN_CYC (PRESS_MIN_CYC_P),
    .MAX_CYC (PRESS_MAX_CYC_P),
    .CNT_W   (PRESS_CNT_W_P)
  ) u_press (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .pressed (btn_sync),
    .accept  (press_accept),
    .reject  (press_reject)
  );

  // wait until the synchronisers hold real pin levels before sampling straps
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      init_reg <= 2'h0;
    end else if (state_reg == ST_INIT && init_reg != INIT_WAIT) begin
      init_reg <= init_reg + 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_cap_reg <= 3'h0;
    end else if (state_reg == ST_INIT && init_reg == INIT_WAIT) begin
      mode_cap_reg <= mode_sync;
    end
  end

  // rewiring the mode at run time would change the function set silently
  assign mode_moved = (mode_sync != mode_cap_reg);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_INIT: begin
        if (init_reg == INIT_WAIT) begin
          if (!cmil_mode_legal(mode_sync)) begin
            state_next = ST_FAULT;
          end else if (cmil_mode_interlock(mode_sync)) begin
            state_next = ST_LOCKED;
          end else begin
            state_next = ST_AUTO;
          end
        end
      end
      ST_AUTO: begin
        if (mode_moved) begin
          state_next = ST_FAULT;
        end
      end
      ST_LOCKED: begin
        if (mode_moved) begin
          state_next = ST_FAULT;
        end else if (press_accept && field_sync && supply_sync) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (mode_moved) begin
          state_next = ST_FAULT;
        end else if (!field_sync || !supply_sync) begin
          state_next = ST_LOCKED;
        end
      end
      ST_FAULT: begin
        state_next = ST_FAULT;
      end
      default: begin
        state_next = ST_FAULT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_reg <= ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs follow field and supply only; no contactor feedback input exists
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      SAFETY_OUT <= 1'b0;
    end else begin
      SAFETY_OUT <= (state_next == ST_ON) ||
                    (state_next == ST_AUTO && field_sync && supply_sync);
    end
  end

  // ready-to-unlock lamp: locked, field free and supply present
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      INTERLOCK_WAIT <= 1'b0;
    end else begin
      INTERLOCK_WAIT <= (state_next == ST_LOCKED) && field_sync && supply_sync;
    end
  end

  // the stored channel lives in an external non-volatile cell; erased cell
  // reads as the first channel, so no factory write is needed
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RX_CHANNEL <= 1'b0;
      NV_WR      <= 1'b0;
      NV_DATA    <= 1'b0;
    end else begin
      NV_WR <= 1'b0;
      if (state_reg == ST_INIT && init_reg == INIT_WAIT) begin
        if (strap_sync) begin
          RX_CHANNEL <= !nv_sync;
          NV_DATA    <= !nv_sync;
          NV_WR      <= 1'b1;
        end else begin
          RX_CHANNEL <= nv_sync;
          NV_DATA    <= nv_sync;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      TX_CHANNEL    <= 1'b0;
      TX_POWER_HALF <= 1'b0;
    end else begin
      TX_CHANNEL    <= pol_sync;
      TX_POWER_HALF <= range_sync;
    end
  end

  // different carrier periods per channel keep neighbouring pairs apart
  assign carrier_half = TX_CHANNEL ? CARRIER_HALF_SECOND : CARRIER_HALF_FIRST;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      carrier_reg <= 8'h00;
      BEAM_MOD    <= 1'b0;
    end else if (!ctrl_reg[CTRL_BEAM_EN]) begin
      carrier_reg <= 8'h00;
      BEAM_MOD    <= 1'b0;
    end else if (carrier_reg >= carrier_half - 8'h01) begin
      carrier_reg <= 8'h00;
      BEAM_MOD    <= !BEAM_MOD;
    end else begin
      carrier_reg <= carrier_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET;
    end else if (WR && ADDR == OFS_CTRL) begin
      ctrl_reg <= {31'h0, WDATA[CTRL_BEAM_EN]};
    end
  end

  assign count_clr = WR && ADDR == OFS_COUNT;

  // a press that completes in the clearing cycle is still counted
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rej_cnt_reg <= 16'h0000;
      acc_cnt_reg <= 16'h0000;
    end else begin
      if (press_reject) begin
        rej_cnt_reg <= count_clr ? 16'h0001 : rej_cnt_reg + 16'h0001;
      end else if (count_clr) begin
        rej_cnt_reg <= 16'h0000;
      end
      if (press_accept) begin
        acc_cnt_reg <= count_clr ? 16'h0001 : acc_cnt_reg + 16'h0001;
      end else if (count_clr) begin
        acc_cnt_reg <= 16'h0000;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        OFS_CTRL: RDATA <= ctrl_reg;
        OFS_STATUS: begin
          RDATA <= 32'h0000_0000;
          RDATA[ST_MODE_LSB +: 3]  <= mode_cap_reg;
          RDATA[ST_LOCK_BIT]       <= cmil_mode_interlock(mode_cap_reg);
          RDATA[ST_OUT_BIT]        <= SAFETY_OUT;
          RDATA[ST_RXCH_BIT]       <= RX_CHANNEL;
          RDATA[ST_TXCH_BIT]       <= TX_CHANNEL;
          RDATA[ST_FAULT_BIT]      <= (state_reg == ST_FAULT);
          RDATA[ST_RANGE_BIT]      <= TX_POWER_HALF;
          RDATA[ST_STATE_LSB +: 3] <= state_reg;
        end
        OFS_COUNT: RDATA <= {acc_cnt_reg, rej_cnt_reg};
        default: RDATA <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  AST_FIXED_FUNC: assert property (
    (state_reg inside {ST_AUTO, ST_LOCKED, ST_ON}) && mode_moved |=> state_reg == ST_FAULT
  ) else $error("mode change did not fault");

  AST_NO_INTERLOCK: assert property (
    (state_reg != ST_INIT) && !cmil_mode_interlock(mode_cap_reg) |->
      !(state_reg inside {ST_LOCKED, ST_ON})
  ) else $error("interlock active in a mode without it");

  AST_AUTO_INTERLOCK: assert property (
    state_reg == ST_INIT && init_reg == INIT_WAIT && cmil_mode_interlock(mode_sync)
      |=> state_reg == ST_LOCKED ##1 !SAFETY_OUT
  ) else $error("interlock not engaged at start");

  AST_STAY_OFF: assert property (
    state_reg == ST_ON && !field_sync && !mode_moved |=> state_reg == ST_LOCKED
      ##1 (!SAFETY_OUT && (state_reg == ST_LOCKED || state_reg == ST_FAULT || press_accept))
  ) else $error("outputs released after field violation");

  AST_SUPPLY_LOSS: assert property (
    state_reg == ST_LOCKED && !press_accept |=> !SAFETY_OUT
  ) else $error("outputs on without reset");

  AST_RELEASE: assert property (
    state_reg == ST_LOCKED && press_accept && field_sync && supply_sync && !mode_moved
      |=> SAFETY_OUT && state_reg == ST_ON
  ) else $error("valid reset did not release outputs");

  AST_IGNORE_BAD: assert property (
    state_reg == ST_LOCKED && press_reject && !mode_moved |=> state_reg == ST_LOCKED
  ) else $error("bad press changed interlock");

  AST_CHAN_TOGGLE: assert property (
    state_reg == ST_INIT && init_reg == INIT_WAIT && strap_sync
      |=> NV_WR && RX_CHANNEL == !$past(nv_sync) && NV_DATA == RX_CHANNEL
  ) else $error("strapped start did not toggle channel");

  AST_CHAN_KEEP: assert property (
    state_reg == ST_INIT && init_reg == INIT_WAIT && !strap_sync
      |=> !NV_WR && RX_CHANNEL == $past(nv_sync)
  ) else $error("stored channel not kept");

  AST_TX_CHAN: assert property (
    $changed(pol_sync) |=> TX_CHANNEL == $past(pol_sync) ##1 TX_CHANNEL == $past(pol_sync, 2)
  ) else $error("transmit channel not following polarity");

  AST_CARRIER: assert property (
    ctrl_reg[CTRL_BEAM_EN] && $changed(BEAM_MOD) |=> !$changed(BEAM_MOD)
  ) else $error("carrier toggled too fast");

  COV_RELEASE: cover property (state_reg == ST_LOCKED ##1 state_reg == ST_ON);
  COV_RELOCK: cover property (state_reg == ST_ON ##1 state_reg == ST_LOCKED);
  COV_REJECT: cover property (state_reg == ST_LOCKED && press_reject);
  COV_TOGGLE: cover property (NV_WR && RX_CHANNEL);

endmodule : cmil_top

// >>> test/cmil_nv_model.sv
`timescale 1ns/10ps
module cmil_nv_model (
  input  wire logic clk,
  input  wire logic nv_wr,
  input  wire logic nv_data,
  output logic      nv_channel
);
  // the cell keeps its content across device resets, since reset stands for power-up
  initial nv_channel = 1'b0;
  always @(posedge clk) begin
    if (nv_wr) begin
      nv_channel <= nv_data;
    end
  end
endmodule : cmil_nv_model

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import cmil_pkg::*;
  localparam int MIN_P = 10;
  localparam int MAX_P = 40;
  localparam logic [2:0] MODES [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  logic        CLK_SYS = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [31:0] RDATA;
  logic [2:0]  MODE_SEL = 3'h1;
  logic        FIELD_CLEAR = 1'b1;
  logic        RESET_BTN = 1'b0;
  logic        STRAP_TIED = 1'b0;
  logic        NV_CHANNEL;
  logic        SUPPLY_OK = 1'b1;
  logic        TX_POLARITY_REV = 1'b0;
  logic        RANGE_REDUCE = 1'b0;
  logic        SAFETY_OUT, INTERLOCK_WAIT, RX_CHANNEL, TX_CHANNEL;
  logic        BEAM_MOD, TX_POWER_HALF, NV_WR, NV_DATA;
  int          num_errors = 0;
  int          total_checks = 0;
  int          seed = 68;
  int          acc;
  int          rej;
  int          lens [8];
  bit          locked;
  bit          ch;
  bit          ilk;
  logic [2:0]  m;
  logic [31:0] d;

  always #5 CLK_SYS = ~CLK_SYS;

  cmil_top #(.PRESS_MIN_CYC_P(MIN_P), .PRESS_MAX_CYC_P(MAX_P), .PRESS_CNT_W_P(29)) DUT (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MODE_SEL(MODE_SEL), .FIELD_CLEAR(FIELD_CLEAR), .RESET_BTN(RESET_BTN),
    .STRAP_TIED(STRAP_TIED), .NV_CHANNEL(NV_CHANNEL), .SUPPLY_OK(SUPPLY_OK),
    .TX_POLARITY_REV(TX_POLARITY_REV), .RANGE_REDUCE(RANGE_REDUCE),
    .SAFETY_OUT(SAFETY_OUT), .INTERLOCK_WAIT(INTERLOCK_WAIT), .RX_CHANNEL(RX_CHANNEL),
    .TX_CHANNEL(TX_CHANNEL), .BEAM_MOD(BEAM_MOD), .TX_POWER_HALF(TX_POWER_HALF),
    .NV_WR(NV_WR), .NV_DATA(NV_DATA));

  cmil_nv_model NV (.clk(CLK_SYS), .nv_wr(NV_WR), .nv_data(NV_DATA), .nv_channel(NV_CHANNEL));

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_bit

  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
  endtask : tick

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : reg_rd

  // reset stands for a power cycle; pins settle well before release so capture is clean
  task automatic power_up(input logic [2:0] md, input logic s);
    RST_N <= 1'b0;
    MODE_SEL <= md;
    STRAP_TIED <= s;
    FIELD_CLEAR <= 1'b1;
    SUPPLY_OK <= 1'b1;
    tick(10);
    RST_N <= 1'b1;
    tick(8);
    STRAP_TIED <= 1'b0;
    ilk = (md == 3'h4) || (md == 3'h6);
    locked = ilk;
  endtask : power_up

  task automatic press(input int k);
    RESET_BTN <= 1'b1;
    tick(k);
    RESET_BTN <= 1'b0;
    tick(8);
    if (k >= MIN_P && k <= MAX_P) begin
      acc++;
      locked = 1'b0;
    end else begin
      rej++;
    end
    #1 check_bit(SAFETY_OUT, !locked);
    check_bit(INTERLOCK_WAIT, locked);
  endtask : press

  // drops field or supply, then restores it; the interlock must hold the outputs off
  task automatic blip(input bit sup);
    if (sup) SUPPLY_OK <= 1'b0;
    else FIELD_CLEAR <= 1'b0;
    tick(6);
    SUPPLY_OK <= 1'b1;
    FIELD_CLEAR <= 1'b1;
    #1 check_bit(SAFETY_OUT, 1'b0);
    locked = ilk;
    tick(6);
    #1 check_bit(SAFETY_OUT, !locked);
  endtask : blip

  task automatic beam_half(input int exp);
    int c;
    logic b;
    c = 100;
    b = BEAM_MOD;
    repeat (100) begin
      @(negedge CLK_SYS);
      if (BEAM_MOD !== b) break;
    end
    if (BEAM_MOD !== b) c = 0;
    b = BEAM_MOD;
    while (BEAM_MOD === b && c < 100) begin
      @(negedge CLK_SYS);
      c++;
    end
    check_word(c, exp);
  endtask : beam_half

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    ch = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 1) ch = !ch;
      TX_POLARITY_REV <= ch;
      RANGE_REDUCE <= 1'($random(seed));
      power_up(3'h1, i % 2 == 1);
      #1 check_bit(RX_CHANNEL, ch);
      check_bit(TX_CHANNEL, ch);
      check_bit(TX_POWER_HALF, RANGE_REDUCE);
      beam_half(ch ? CARRIER_HALF_SECOND : CARRIER_HALF_FIRST);
    end
    $display("test channels done");
    reg_rd(OFS_CTRL, d);
    check_word(d, 32'h1);
    reg_rd(8'h0c, d);
    check_word(d, 32'h0);
    reg_wr(OFS_CTRL, 32'h0);
    tick(70);
    #1 check_bit(BEAM_MOD, 1'b0);
    reg_wr(OFS_CTRL, 32'h1);
    $display("test registers done");
    lens = '{9, 41, 10, 40, 0, 0, 0, 0};
    for (int i = 0; i < 5; i++) begin
      m = MODES[i];
      for (int j = 4; j < 8; j++) lens[j] = 1 + ($unsigned($random(seed)) % 60);
      power_up(m, 1'b0);
      reg_wr(OFS_COUNT, 32'h0);
      acc = 0;
      rej = 0;
      reg_rd(OFS_STATUS, d);
      check_word(d[3:0], {ilk, m});
      check_word(d[8:4], {RANGE_REDUCE, 1'b0, TX_POLARITY_REV, ch, !ilk});
      check_bit(SAFETY_OUT, !ilk);
      foreach (lens[j]) begin
        press(lens[j]);
        if (!locked) blip(j % 2);
      end
      reg_rd(OFS_COUNT, d);
      check_word(d, {acc[15:0], rej[15:0]});
      MODE_SEL <= m ^ 3'h1;
      tick(8);
      reg_rd(OFS_STATUS, d);
      check_word(d[11:9], 3'h4);
      check_bit(SAFETY_OUT, 1'b0);
      $display("test mode %0d done", m);
    end
    // an unlisted mode code must never enable any function set
    power_up(3'h5, 1'b0);
    reg_rd(OFS_STATUS, d);
    check_word(d[11:9], 3'h4);
    check_bit(d[ST_FAULT_BIT], 1'b1);
    check_bit(SAFETY_OUT, 1'b0);
    $display("test illegal mode done");
    close_out();
  end
endmodule : testbench
